// [design/pft_params.svh]
// Constants for the program flash table access block
`ifndef PFT_PARAMS_SVH
`define PFT_PARAMS_SVH

// --------------------------------------------------------------
// Register selects on the special function register port
// --------------------------------------------------------------
`define PFT_SEL_CTRL 3'h0
`define PFT_SEL_KEY 3'h1
`define PFT_SEL_LATCH 3'h2
`define PFT_SEL_PTRU 3'h3
`define PFT_SEL_PTRH 3'h4
`define PFT_SEL_PTRL 3'h5

// --------------------------------------------------------------
// flash_control field positions and reset values
// --------------------------------------------------------------
`define PFT_BIT_ERASE 4
`define PFT_BIT_ERR 3
`define PFT_BIT_WRITE_ALLOW 2
`define PFT_BIT_WR 1
`define PFT_CTRL_RST 1'b0
`define PFT_ERR_COLD 1'b0
`define PFT_LATCH_RST 8'h00
`define PFT_PTR_RST 22'h000000

// --------------------------------------------------------------
// Unlock keys, geometry and codes
// --------------------------------------------------------------
`define PFT_KEY1 8'h55
`define PFT_KEY2 8'haa
`define PFT_HOLD_BYTES 64
`define PFT_ERASE_WORDS 512
`define PFT_PROG_WORDS 32
`define PFT_ERASED_WORD 16'hffff
`define PFT_NOP_WORD 16'h0000
`define PFT_BAD_WORD 16'hffff
`define PFT_UNMAPPED_BYTE 8'hff

// --------------------------------------------------------------
// Timing
// --------------------------------------------------------------
`define PFT_CLK_MHZ 50
`define PFT_T_WRITE_US 1000
`define PFT_T_ERASE_US 1000

`endif

// [design/pft_pkg.sv]
// Types shared by the program flash table access block
package pft_pkg;

    // Timed operation state, one-hot
    typedef enum logic [2:0] {
        PFT_IDLE = 3'b001,
        PFT_PROG = 3'b010,
        PFT_ERASE = 3'b100
    } pft_state_t;

    // Pointer treatment of a table operation
    typedef enum logic [1:0] {
        PFT_MODE_KEEP = 2'h0,
        PFT_MODE_POSTINC = 2'h1,
        PFT_MODE_POSTDEC = 2'h2,
        PFT_MODE_PREINC = 2'h3
    } pft_mode_t;

    // Register access from the core
    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] sel;
        logic [7:0] wdata;
    } pft_sfr_t;

    // Table read or write request from the core
    typedef struct packed {
        logic req;
        logic write;
        pft_mode_t mode;
    } pft_tbl_t;

    // Unlock progress, one-hot
    typedef enum logic [2:0] {
        PFT_LOCKED = 3'b001,
        PFT_KEY1_SEEN = 3'b010,
        PFT_ARMED = 3'b100
    } pft_unlock_t;

endpackage : pft_pkg

// [design/pft_flash_table.sv]
// Flash program memory with table read, table write, block program and block erase
//
// Function
// - Byte reads, 64-byte program, 1024-byte erase
// - No whole-array erase from the core
// - Halt fetch until timer ends operation
// - Invalid instruction word executes as no-op
// - 16-bit array, transfers through 8-bit latch
// - Table write fills holding register only
// - Low six pointer bits select holding register
// - Unlock register unstored, reads zero
// - Erase-select picks erase, cleared on completion
// - Write-allow clear at power-up, gates operations
// - Error flag set on start, cleared normally
// - Write-start set-only, cleared by hardware
// - Control bits 7-5 and 0 read zero
// - 22-bit pointer, top bit selects ID space
// - Auto-modify touches low 21 bits only
// - Four pointer modes per table operation
// - Read uses all 22 pointer bits
// - Pointer bits 21-6 select programmed block
// - Erase uses top 12 bits, rest ignored
// - Pointer bit 0 picks word byte
// - Holding registers kept after completion
`timescale 1ns/1ps

`include "pft_params.svh"

module pft_flash_table #(
    parameter int ADDR_W = 12,
    parameter int WRITE_CYC = `PFT_T_WRITE_US * `PFT_CLK_MHZ,
    parameter int ERASE_CYC = `PFT_T_ERASE_US * `PFT_CLK_MHZ,
    parameter logic [7:0] ID_BYTE = 8'h3c // Arbitrary ID space content
) (
    // Clock and resets
    input wire logic clk,
    input wire logic reset,
    input wire logic cold_reset,
    // Register access
    input wire pft_pkg::pft_sfr_t sfr,
    output logic [7:0] sfr_rdata,
    // Table operations
    input wire pft_pkg::pft_tbl_t tbl,
    output logic tbl_done,
    // Instruction fetch
    input wire logic fetch_req,
    input wire logic [ADDR_W-1:0] fetch_addr,
    output logic [15:0] fetch_instr,
    output logic fetch_valid,
    output logic fetch_halt
);
    import pft_pkg::*;

    localparam int CW = 24;

    // --------------------------------------------------------------
    // Storage and state
    // --------------------------------------------------------------
    logic [15:0] mem [0:(2**ADDR_W)-1];
    logic [7:0] hold [0:`PFT_HOLD_BYTES-1];
    pft_state_t state_r;
    pft_unlock_t unlock_r;
    logic [CW-1:0] cnt_r;
    logic [9:0] idx_r;
    logic [21:0] ptr_r;
    logic [21:0] blk_r;
    logic [7:0] lat_r;
    logic erase_r;
    logic write_allow_r;
    logic err_r;

    // --------------------------------------------------------------
    // Access address and read path
    // --------------------------------------------------------------
    logic [21:0] ptr_inc;
    logic [21:0] ptr_dec;
    logic [21:0] acc_ptr;
    logic [15:0] rd_word;
    logic [7:0] rd_byte;
    logic in_array;
    logic busy;
    logic wr_attempt;
    logic start;
    logic last;
    logic [9:0] op_words;
    logic [ADDR_W-1:0] op_addr;
    logic [15:0] op_data;

    // Modify only the low 21 bits so the ID space bit stays put
    assign ptr_inc = {ptr_r[21], ptr_r[20:0] + 21'h000001};
    assign ptr_dec = {ptr_r[21], ptr_r[20:0] - 21'h000001};
    assign acc_ptr = (tbl.mode == PFT_MODE_PREINC) ? ptr_inc : ptr_r;
    assign busy = (state_r != PFT_IDLE);

    // Byte address beyond the implemented array reads as erased
    assign in_array = (acc_ptr[20:ADDR_W+1] == '0);
    assign rd_word = mem[acc_ptr[ADDR_W:1]];

    // Select byte of the word, or ID space on the top pointer bit
    always_comb begin
        if (acc_ptr[21]) begin
            rd_byte = ID_BYTE;
        end else if (!in_array) begin
            rd_byte = `PFT_UNMAPPED_BYTE;
        end else if (acc_ptr[0]) begin
            rd_byte = rd_word[15:8];
        end else begin
            rd_byte = rd_word[7:0];
        end
    end

    // An attempt to set write-start; it only starts when armed and allowed
    assign wr_attempt = sfr.wr && (sfr.sel == `PFT_SEL_CTRL) && sfr.wdata[`PFT_BIT_WR] && !busy;
    assign start = wr_attempt && write_allow_r && (unlock_r == PFT_ARMED);

    // Word count and target of the running operation
    assign op_words = (state_r == PFT_ERASE) ? 10'(`PFT_ERASE_WORDS) : 10'(`PFT_PROG_WORDS);
    assign last = (state_r == PFT_ERASE) ? (cnt_r == CW'(ERASE_CYC - 1))
                                         : (cnt_r == CW'(WRITE_CYC - 1));

    // Erase ignores bits 9:0; program places a 64-byte row in the 1024-byte block
    always_comb begin
        if (state_r == PFT_ERASE) begin
            op_addr = {blk_r[ADDR_W:10], idx_r[8:0]};
            op_data = `PFT_ERASED_WORD;
        end else begin
            op_addr = {blk_r[ADDR_W:6], idx_r[4:0]};
            op_data = {hold[{idx_r[4:0], 1'b1}], hold[{idx_r[4:0], 1'b0}]};
        end
    end

    // --------------------------------------------------------------
    // Timed operation sequencer
    // --------------------------------------------------------------

    // Only block sizes exist here; there is no path to a whole-array erase
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= PFT_IDLE;
        end else begin
            case (state_r)
                PFT_IDLE: begin
                    if (start) begin
                        state_r <= erase_r ? PFT_ERASE : PFT_PROG;
                    end
                end
                PFT_PROG, PFT_ERASE: begin
                    if (last) begin
                        state_r <= PFT_IDLE;
                    end
                end
                default: state_r <= PFT_IDLE;
            endcase
        end
    end

    // Programming timer and word index
    always_ff @(posedge clk) begin
        if (reset || !busy) begin
            cnt_r <= '0;
            idx_r <= '0;
        end else begin
            cnt_r <= cnt_r + CW'(1);
            if (idx_r != op_words) begin
                idx_r <= idx_r + 10'h001;
            end
        end
    end

    // Block address is frozen at start so later pointer changes are harmless
    always_ff @(posedge clk) begin
        if (reset) begin
            blk_r <= `PFT_PTR_RST;
        end else if (start) begin
            blk_r <= ptr_r;
        end
    end

    // Array update: one word per cycle from the start until the whole block is written, never in ID space
    always_ff @(posedge clk) begin
        if (busy && (idx_r != op_words) && !blk_r[21]
            && (blk_r[20:ADDR_W+1] == '0)) begin
            mem[op_addr] <= op_data;
        end
    end

    // --------------------------------------------------------------
    // Holding registers
    // --------------------------------------------------------------

    // No reset: contents survive completion and must be rewritten by software
    always_ff @(posedge clk) begin
        if (tbl.req && tbl.write && !busy) begin
            hold[acc_ptr[5:0]] <= lat_r;
        end
    end

    // --------------------------------------------------------------
    // Control register bits
    // --------------------------------------------------------------

    // Write-allow and erase-select; erase completion clears erase-select
    always_ff @(posedge clk) begin
        if (reset) begin
            write_allow_r <= `PFT_CTRL_RST;
            erase_r <= `PFT_CTRL_RST;
        end else begin
            if (sfr.wr && (sfr.sel == `PFT_SEL_CTRL) && !busy) begin
                write_allow_r <= sfr.wdata[`PFT_BIT_WRITE_ALLOW];
                erase_r <= sfr.wdata[`PFT_BIT_ERASE];
            end
            if ((state_r == PFT_ERASE) && last) begin
                erase_r <= 1'b0;
            end
        end
    end

    // Error flag: a reset during an operation leaves it set; a cold reset, a normal
    // timer expiry or a control write with the bit at zero clears it; hardware set wins over writes
    always_ff @(posedge clk) begin
        if (reset) begin
            if (cold_reset) begin
                err_r <= `PFT_ERR_COLD;
            end else if (busy) begin
                err_r <= 1'b1;
            end
        end else if (wr_attempt) begin
            err_r <= 1'b1;
        end else if (busy && last) begin
            err_r <= 1'b0;
        end else if (sfr.wr && (sfr.sel == `PFT_SEL_CTRL)) begin
            err_r <= sfr.wdata[`PFT_BIT_ERR];
        end
    end

    // Unlock sequence: any other register write breaks it
    always_ff @(posedge clk) begin
        if (reset) begin
            unlock_r <= PFT_LOCKED;
        end else if (sfr.wr) begin
            if (sfr.sel != `PFT_SEL_KEY) begin
                unlock_r <= PFT_LOCKED;
            end else if (sfr.wdata == `PFT_KEY1) begin
                unlock_r <= PFT_KEY1_SEEN;
            end else if ((sfr.wdata == `PFT_KEY2) && (unlock_r == PFT_KEY1_SEEN)) begin
                unlock_r <= PFT_ARMED;
            end else begin
                unlock_r <= PFT_LOCKED;
            end
        end
    end

    // --------------------------------------------------------------
    // Table pointer and latch
    // --------------------------------------------------------------

    // A table operation takes priority over a register write in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            ptr_r <= `PFT_PTR_RST;
        end else if (tbl.req && !busy) begin
            case (tbl.mode)
                PFT_MODE_KEEP: ptr_r <= ptr_r;
                PFT_MODE_POSTINC: ptr_r <= ptr_inc;
                PFT_MODE_POSTDEC: ptr_r <= ptr_dec;
                PFT_MODE_PREINC: ptr_r <= ptr_inc;
                default: ptr_r <= ptr_r;
            endcase
        end else if (sfr.wr) begin
            case (sfr.sel)
                `PFT_SEL_PTRU: ptr_r[21:16] <= sfr.wdata[5:0];
                `PFT_SEL_PTRH: ptr_r[15:8] <= sfr.wdata;
                `PFT_SEL_PTRL: ptr_r[7:0] <= sfr.wdata;
                default: ptr_r <= ptr_r;
            endcase
        end
    end

    // Latch gets the read byte; software may also load it directly
    always_ff @(posedge clk) begin
        if (reset) begin
            lat_r <= `PFT_LATCH_RST;
        end else if (tbl.req && !tbl.write && !busy) begin
            lat_r <= rd_byte;
        end else if (sfr.wr && (sfr.sel == `PFT_SEL_LATCH)) begin
            lat_r <= sfr.wdata;
        end
    end

    // Completion pulse for table operations
    always_ff @(posedge clk) begin
        if (reset) begin
            tbl_done <= 1'b0;
        end else begin
            tbl_done <= tbl.req && !busy;
        end
    end

    // --------------------------------------------------------------
    // Register read-back
    // --------------------------------------------------------------

    // One cycle after the read strobe; unknown selects read zero
    always_ff @(posedge clk) begin
        if (reset) begin
            sfr_rdata <= 8'h00;
        end else if (sfr.rd) begin
            case (sfr.sel)
                `PFT_SEL_CTRL: sfr_rdata <= {3'h0, erase_r, err_r, write_allow_r, busy, 1'b0};
                `PFT_SEL_KEY: sfr_rdata <= 8'h00;
                `PFT_SEL_LATCH: sfr_rdata <= lat_r;
                `PFT_SEL_PTRU: sfr_rdata <= {2'h0, ptr_r[21:16]};
                `PFT_SEL_PTRH: sfr_rdata <= ptr_r[15:8];
                `PFT_SEL_PTRL: sfr_rdata <= ptr_r[7:0];
                default: sfr_rdata <= 8'h00;
            endcase
        end
    end

    // --------------------------------------------------------------
    // Instruction fetch
    // --------------------------------------------------------------

    // The array is unreadable while an operation runs, so fetch stalls
    always_ff @(posedge clk) begin
        if (reset) begin
            fetch_halt <= 1'b0;
            fetch_valid <= 1'b0;
            fetch_instr <= `PFT_NOP_WORD;
        end else begin
            fetch_halt <= start || (busy && !last);
            fetch_valid <= fetch_req && !busy && !start;
            if (fetch_req && !busy) begin
                // Erased or undecodable words run as a no-op
                fetch_instr <= (mem[fetch_addr] == `PFT_BAD_WORD) ? `PFT_NOP_WORD
                                                                : mem[fetch_addr];
            end
        end
    end

endmodule : pft_flash_table

// [sim/pft_asserts.sv]
// Port-level properties of the program flash table access block
`timescale 1ns/1ps
`include "pft_params.svh"
// ------------
// Checker
// ------------
module pft_asserts
import pft_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int WRITE_CYC = 40,
    parameter int ERASE_CYC = 600
) (
    // Clock and resets
    input wire logic clk,
    input wire logic reset,
    input wire logic cold_reset,
    // Register and table ports
    input wire pft_pkg::pft_sfr_t sfr,
    input wire logic [7:0] sfr_rdata,
    input wire pft_pkg::pft_tbl_t tbl,
    input wire logic tbl_done,
    // Fetch port
    input wire logic fetch_req,
    input wire logic [ADDR_W-1:0] fetch_addr,
    input wire logic [15:0] fetch_instr,
    input wire logic fetch_valid,
    input wire logic fetch_halt
);
    int halt_cnt_r;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Stall length, too long to unroll as a repetition
    always_ff @(posedge clk) begin
        if (reset || !fetch_halt) begin
            halt_cnt_r <= 0;
        end else begin
            halt_cnt_r <= halt_cnt_r + 1;
        end
    end
    done_follows_req_a: assert property (
        tbl.req && !fetch_halt && !sfr.wr |=> tbl_done)
        else $error("table request not answered");
    done_cause_a: assert property (
        tbl_done |-> $past(tbl.req) && !$past(fetch_halt))
        else $error("table answer without accepted request");
    fetch_answer_a: assert property (
        fetch_req && !fetch_halt && !sfr.wr |=> fetch_valid)
        else $error("fetch not answered");
    fetch_cause_a: assert property (
        fetch_valid |-> $past(fetch_req) && !$past(fetch_halt))
        else $error("fetch answered while stalled");
    invalid_as_nop_a: assert property (
        fetch_valid |-> fetch_instr != 16'hffff)
        else $error("invalid word delivered");
    key_reads_zero_a: assert property (
        sfr.rd && sfr.sel == `PFT_SEL_KEY |=> sfr_rdata == 8'h00)
        else $error("unlock register not zero");
    ctrl_spare_zero_a: assert property (
        sfr.rd && sfr.sel == `PFT_SEL_CTRL |=> sfr_rdata[7:5] == 3'h0 && !sfr_rdata[0])
        else $error("spare control bits set");
    busy_flags_a: assert property (
        fetch_halt && sfr.rd && sfr.sel == `PFT_SEL_CTRL ##1 fetch_halt
        |-> sfr_rdata[1] && sfr_rdata[3])
        else $error("busy flags clear during stall");
    // A reset cuts the stall short, so only stalls ended by the timer are measured
    stall_length_a: assert property (
        $fell(fetch_halt) && !$past(reset)
        |-> halt_cnt_r == WRITE_CYC || halt_cnt_r == ERASE_CYC)
        else $error("stall length wrong");
    start_cause_a: assert property (
        $rose(fetch_halt) |-> $past(sfr.wr) && $past(sfr.wdata[1]))
        else $error("stall without start write");
endmodule : pft_asserts

// [sim/pft_core_model.sv]
// Processor core model issuing register, table and fetch requests
`timescale 1ns/1ps
`include "pft_params.svh"
module pft_core_model
import pft_pkg::*;
#(parameter int ADDR_W = 12) (
    // Clock
    input wire logic clk,
    // Requests
    output pft_pkg::pft_sfr_t sfr,
    output pft_pkg::pft_tbl_t tbl,
    output logic fetch_req,
    output logic [ADDR_W-1:0] fetch_addr,
    // Answers
    input wire logic [7:0] sfr_rdata,
    input wire logic tbl_done,
    input wire logic [15:0] fetch_instr,
    input wire logic fetch_valid
);
    initial begin
        sfr = '0;
        tbl = '0;
        fetch_req = 1'b0;
        fetch_addr = '0;
    end
    // Released fields show inverted stale values so nothing leans on old data
    task automatic sfr_acc(input logic w, input logic [2:0] s, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge clk);
        sfr <= '{wr: w, rd: !w, sel: s, wdata: d};
        @(posedge clk);
        sfr <= '{wr: 1'b0, rd: 1'b0, sel: ~s, wdata: ~d};
        #1 q = sfr_rdata;
    endtask : sfr_acc
    // Unlock keys then the start write, with no other register write between
    task automatic start_op(input logic [7:0] ctrl);
        logic [7:0] q;
        sfr_acc(1'b1, `PFT_SEL_KEY, `PFT_KEY1, q);
        sfr_acc(1'b1, `PFT_SEL_KEY, `PFT_KEY2, q);
        sfr_acc(1'b1, `PFT_SEL_CTRL, ctrl, q);
    endtask : start_op
    task automatic tbl_op(input logic w, input pft_mode_t m, output logic done);
        @(posedge clk);
        tbl <= '{req: 1'b1, write: w, mode: m};
        @(posedge clk);
        tbl <= '{req: 1'b0, write: !w, mode: m};
        #1 done = tbl_done;
    endtask : tbl_op
    task automatic fetch(input logic [ADDR_W-1:0] a, output logic v, output logic [15:0] q);
        @(posedge clk);
        fetch_req <= 1'b1;
        fetch_addr <= a;
        @(posedge clk);
        fetch_req <= 1'b0;
        fetch_addr <= ~a;
        #1 v = fetch_valid;
        q = fetch_instr;
    endtask : fetch
endmodule : pft_core_model

// [sim/tb.sv]
// Self-checking testbench for the program flash table access block
`timescale 1ns/1ps
`include "pft_params.svh"
module tb;
    import pft_pkg::*;
    localparam int ADDR_W = 12;
    localparam int WRITE_CYC = 40;
    localparam int ERASE_CYC = 600;
    localparam logic [7:0] ID_BYTE = 8'h5a; // Arbitrary ID space content
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic cold_reset = 1'b1;
    pft_sfr_t sfr;
    pft_tbl_t tbl;
    logic [7:0] sfr_rdata;
    logic [ADDR_W-1:0] fetch_addr;
    logic [15:0] fetch_instr;
    logic tbl_done, fetch_req, fetch_valid, fetch_halt;
    int ptr, miscompares, comparisons;
    logic [7:0] rd_q;
    logic [7:0] hold [64];
    logic [7:0] mem [int];
    always #10 clk = ~clk;
    pft_flash_table #(.ADDR_W(ADDR_W), .WRITE_CYC(WRITE_CYC), .ERASE_CYC(ERASE_CYC),
        .ID_BYTE(ID_BYTE)) DUT (.clk(clk), .reset(reset), .cold_reset(cold_reset), .sfr(sfr),
        .sfr_rdata(sfr_rdata), .tbl(tbl), .tbl_done(tbl_done), .fetch_req(fetch_req),
        .fetch_addr(fetch_addr), .fetch_instr(fetch_instr), .fetch_valid(fetch_valid),
        .fetch_halt(fetch_halt));
    pft_core_model #(.ADDR_W(ADDR_W)) u_core (.clk(clk), .sfr(sfr), .tbl(tbl),
        .fetch_req(fetch_req), .fetch_addr(fetch_addr), .sfr_rdata(sfr_rdata),
        .tbl_done(tbl_done), .fetch_instr(fetch_instr), .fetch_valid(fetch_valid));
    task automatic check(input logic [21:0] seen, input logic [21:0] want, input string what);
        comparisons++;
        if (seen !== want) begin
            miscompares++;
            $display("BAD %0t %s seen %h want %h", $time, what, seen, want);
        end
    endtask : check
    task automatic print_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict
    // Pointer steps move the low 21 bits only
    function automatic int bump(int p, int d);
        return (p & 32'h200000) | ((p + d) & 32'h1fffff);
    endfunction : bump
    function automatic logic [15:0] exp_word(int a);
        logic [15:0] w;
        w = {mem[a + 1], mem[a]};
        return (w == 16'hffff) ? 16'h0000 : w;
    endfunction : exp_word
    task automatic rd_reg(input logic [2:0] s, input logic [7:0] want);
        logic [7:0] q;
        u_core.sfr_acc(1'b0, s, 8'h00, q);
        check(22'(q), 22'(want), "register");
    endtask : rd_reg
    task automatic set_ptr(input logic [21:0] p);
        logic [7:0] q;
        u_core.sfr_acc(1'b1, `PFT_SEL_PTRU, {2'h0, p[21:16]}, q);
        u_core.sfr_acc(1'b1, `PFT_SEL_PTRH, p[15:8], q);
        u_core.sfr_acc(1'b1, `PFT_SEL_PTRL, p[7:0], q);
        ptr = int'(p);
    endtask : set_ptr
    task automatic check_ptr();
        rd_reg(`PFT_SEL_PTRU, {2'h0, ptr[21:16]});
        rd_reg(`PFT_SEL_PTRH, ptr[15:8]);
        rd_reg(`PFT_SEL_PTRL, ptr[7:0]);
    endtask : check_ptr
    // Table operation mirrored in the reference pointer and holding model
    task automatic tbl_step(input logic w, input pft_mode_t m, input logic [7:0] d);
        logic dn;
        logic [7:0] q;
        if (w) u_core.sfr_acc(1'b1, `PFT_SEL_LATCH, d, q);
        if (m == PFT_MODE_PREINC) ptr = bump(ptr, 1);
        u_core.tbl_op(w, m, dn);
        check(22'(dn), 22'h1, "table done");
        if (w) begin
            hold[ptr & 63] = d;
        end else if (ptr[21] || mem.exists(ptr)) begin
            rd_reg(`PFT_SEL_LATCH, ptr[21] ? ID_BYTE : mem[ptr]);
        end
        if (m == PFT_MODE_POSTINC) ptr = bump(ptr, 1);
        if (m == PFT_MODE_POSTDEC) ptr = bump(ptr, -1);
    endtask : tbl_step
    task automatic check_block(input logic [21:0] b);
        logic v;
        logic [15:0] q;
        set_ptr(b);
        for (int i = 0; i < 64; i++) tbl_step(1'b0, PFT_MODE_POSTINC, 8'h00);
        for (int i = 0; i < 32; i++) begin
            u_core.fetch(ADDR_W'(b[21:1] + i), v, q);
            check(22'(v), 22'h1, "fetch valid");
            check(22'(q), 22'(exp_word(b + 2 * i)), "fetch word");
        end
    endtask : check_block
    // Start a timed operation; fetch and table requests must wait it out
    task automatic timed_op(input logic [7:0] ctrl, input int cyc);
        int n;
        logic v;
        logic [15:0] q;
        // Allow and erase-select go in first; the start write acts on the stored bits
        u_core.sfr_acc(1'b1, `PFT_SEL_CTRL, ctrl & 8'hfd, rd_q);
        u_core.start_op(ctrl);
        check(22'(fetch_halt), 22'h1, "halt");
        rd_reg(`PFT_SEL_CTRL, ctrl | 8'h08);
        u_core.fetch('0, v, q);
        check(22'(v), 22'h0, "fetch while halted");
        u_core.tbl_op(1'b0, PFT_MODE_KEEP, v);
        check(22'(v), 22'h0, "table while halted");
        n = 0;
        while (fetch_halt === 1'b1 && n < cyc + 10) begin
            @(posedge clk);
            #1 n++;
        end
        check(22'(n), 22'(cyc - 6), "stall length");
        rd_reg(`PFT_SEL_CTRL, ctrl & 8'h04);
    endtask : timed_op
    task automatic commit();
        for (int i = 0; i < 64; i++) mem[(ptr & 32'h1fc0) + i] = hold[i];
    endtask : commit
    initial begin
        #200_000;
        miscompares++;
        print_verdict();
    end
    initial begin
        void'($urandom(13274));
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        cold_reset <= 1'b0;
        rd_reg(`PFT_SEL_CTRL, 8'h00);
        rd_reg(`PFT_SEL_KEY, 8'h00);
        check_ptr();
        // Refused starts: no write-allow, then allow without unlock
        u_core.start_op(8'h02);
        check(22'(fetch_halt), 22'h0, "refused start");
        rd_reg(`PFT_SEL_CTRL, 8'h08);
        set_ptr(22'h0003ff);
        u_core.sfr_acc(1'b1, `PFT_SEL_CTRL, 8'h04, rd_q);
        u_core.sfr_acc(1'b1, `PFT_SEL_CTRL, 8'h06, rd_q);
        check(22'(fetch_halt), 22'h0, "start without unlock");
        rd_reg(`PFT_SEL_CTRL, 8'h0c);
        for (int i = 0; i < 64; i++) tbl_step(1'b1, PFT_MODE_PREINC, 8'($urandom));
        timed_op(8'h06, WRITE_CYC);
        commit();
        check_block(22'h000400);
        // Erase ignores the pointer bits below the block
        set_ptr(22'h0005a3);
        timed_op(8'h16, ERASE_CYC);
        for (int b = 32'h400; b < 32'h800; b++) mem[b] = 8'hff;
        check_block(22'h000400);
        set_ptr(22'h000400);
        timed_op(8'h06, WRITE_CYC);
        commit();
        set_ptr(22'h0003ff);
        tbl_step(1'b1, PFT_MODE_PREINC, ~hold[0]);
        check_block(22'h000400);
        // All pointer modes at the top of the ID space, where the low 21 bits wrap
        set_ptr(22'h3fffff);
        for (int m = 0; m < 4; m++) begin
            tbl_step(1'b0, pft_mode_t'(m), 8'h00);
            check_ptr();
        end
        // Reset in mid-erase leaves the error flag up and clears the pointer
        u_core.sfr_acc(1'b1, `PFT_SEL_CTRL, 8'h14, rd_q);
        u_core.start_op(8'h16);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        rd_reg(`PFT_SEL_CTRL, 8'h08);
        ptr = 0;
        check_ptr();
        print_verdict();
    end
endmodule : tb
bind pft_flash_table pft_asserts #(.ADDR_W(ADDR_W), .WRITE_CYC(WRITE_CYC),
    .ERASE_CYC(ERASE_CYC)) u_chk (.clk(clk), .reset(reset), .cold_reset(cold_reset),
    .sfr(sfr), .sfr_rdata(sfr_rdata), .tbl(tbl), .tbl_done(tbl_done), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_instr(fetch_instr), .fetch_valid(fetch_valid),
    .fetch_halt(fetch_halt));
